// ---- hdl/dcr_register_map.sv ----
// Network register map: control selection, option output words, status and fault monitor words.
// Assumes the network front end presents decoded word requests synchronous to clk.
//
// Summary of operation
// [R1] Control word bit 1 selects network PID setpoint; bit 2 network torque reference/limit.
// [R2] Control word bit 3 selects network torque compensation over the local value.
// [R3] Control word bits C..F enable inputs five to eight for broadcast data.
// [R4] Control bit 0, bits 4..B and registers 10..1A, 1E..1F are reserved.
// [R5] Option analog outputs follow registers 1B and 1C; 4000 hex is 10 V.
// [R6] Register 1D drives the digital option outputs bit for bit.
// [R7] Monitor words are read-only; writes are refused, reads give live state.
// [R8] Status word 20 reports run, direction, ready, fault, errors, outputs, selections.
// [R9] Fault bits 0..3: overcurrent/ground, overvoltage, overload, overheat.
// [R10] Fault bit 4 braking faults; bit 6 PID feedback loss.
// [R11] Fault bit 7 any external fault; bit 8 any hardware fault.
// [R12] Fault bit 9 motor load/torque faults; bit A encoder and speed faults.
// [R13] Fault bit B main undervoltage; bit C other undervoltage or soft charge.
// [R14] Fault bit D phase loss; bit E communication; bit F keypad connection.
// [R15] Command words read back as well as accept writes.
// [R16] The master writes zeros to unused bits and avoids reserved registers.
// [R17] Each fault bit is the OR of its sources and holds while any is active.
`timescale 1ns/1ns
module dcr_register_map #(
    parameter int AOUT_WIDTH = 16,
    parameter int DOUT_WIDTH = 16
) (
    input  logic                  clk,
    input  logic                  rst_n,
    input  dcr_pkg::dcr_req_t     req,
    output dcr_pkg::dcr_rsp_t     rsp,
    input  dcr_pkg::dcr_status_t  status,
    input  dcr_pkg::dcr_faults_t  faults,
    output dcr_pkg::dcr_sel_t     sel,
    output logic [AOUT_WIDTH-1:0] analogOutOne,
    output logic [AOUT_WIDTH-1:0] analogOutTwo,
    output logic [DOUT_WIDTH-1:0] digitalOut
);
    import dcr_pkg::*;

    // The option words are sixteen bits wide; narrower outputs would drop data.
    if (AOUT_WIDTH != 16 || DOUT_WIDTH != 16) begin : g_width_check
        $error("dcr_register_map: output widths must be 16");
    end

    // Classifies an address into the register it names.
    typedef enum {
        REG_NONE,
        REG_CTRL,
        REG_AOUT1,
        REG_AOUT2,
        REG_DOUT,
        REG_STATE,
        REG_FAULT,
        REG_RSV
    } dcr_reg_t;

    function automatic dcr_reg_t decodeAddr(input logic [15:0] addr);
        dcr_reg_t r;
        r = REG_NONE;
        if (addr == ADDR_CTRL_SEL) begin
            r = REG_CTRL;
        end else if (addr == ADDR_AOUT_ONE) begin
            r = REG_AOUT1;
        end else if (addr == ADDR_AOUT_TWO) begin
            r = REG_AOUT2;
        end else if (addr == ADDR_DOUT) begin
            r = REG_DOUT;
        end else if (addr == ADDR_STATE) begin
            r = REG_STATE;
        end else if (addr == ADDR_FAULT) begin
            r = REG_FAULT;
        end else if ((addr >= ADDR_RSV_A_LO && addr <= ADDR_RSV_A_HI) ||
                     (addr >= ADDR_RSV_B_LO && addr <= ADDR_RSV_B_HI)) begin
            r = REG_RSV; // [R4]
        end
        return r;
    endfunction

    // All state of this module.
    typedef struct packed {
        logic [15:0] ctrlSel;
        logic [15:0] aout1;
        logic [15:0] aout2;
        logic [15:0] dout;
        logic [15:0] stateWord;
        logic [15:0] faultWord;
        dcr_sel_t    sel;
        dcr_rsp_t    rsp;
    } dcr_state_t;

    dcr_state_t  s_q;
    dcr_state_t  s_d;
    logic [15:0] faultLive;
    dcr_reg_t    target;
    logic [15:0] liveState;

    // Fault grouping lives in its own module so the bit assignments are easy to audit.
    dcr_fault_merge u_fault_merge (
        .faults    (faults),
        .faultWord (faultLive)
    );

    // Assemble the live drive state word; reserved bits 8..D read zero.
    always_comb begin
        liveState = 16'h0000;
        liveState[DS_RUN_BIT]  = status.running;                 // [R8]
        liveState[DS_REV_BIT]  = status.reverse;                 // [R8]
        liveState[DS_RDY_BIT]  = status.ready;                   // [R8]
        liveState[DS_FLT_BIT]  = status.fault;                   // [R8]
        liveState[DS_DSE_BIT]  = status.dataSetError;            // [R8]
        liveState[DS_CONT_BIT] = status.contactOut;              // [R8]
        liveState[DS_PC1_BIT]  = status.photoOut1;               // [R8]
        liveState[DS_PC2_BIT]  = status.photoOut2;               // [R8]
        liveState[DS_NREF_BIT] = status.networkReferenceSelect;  // [R8]
        liveState[DS_NCTL_BIT] = status.networkControlSelect;    // [R8]
    end

    assign target = decodeAddr(req.addr);

    // Next-state logic: register writes, one-cycle answers and steering outputs.
    always_comb begin
        s_d = s_q;
        s_d.rsp.ack   = 1'b0;
        s_d.rsp.err   = 1'b0;
        s_d.rsp.rdata = 16'h0000;
        // Monitor words are sampled every cycle; a read returns liveState or faultLive directly, not the samples.
        s_d.stateWord = liveState;  // [R7]
        s_d.faultWord = faultLive;  // [R17]
        if (req.wr) begin
            s_d.rsp.ack = 1'b1;
            case (target)
                REG_CTRL: begin
                    // Reserved bits are held at zero whatever the master sends.
                    s_d.ctrlSel = req.wdata & CSEL_WMASK; // [R4] [R16]
                end
                REG_AOUT1: begin
                    s_d.aout1 = req.wdata; // [R5]
                end
                REG_AOUT2: begin
                    s_d.aout2 = req.wdata; // [R5]
                end
                REG_DOUT: begin
                    s_d.dout = req.wdata; // [R6]
                end
                REG_STATE, REG_FAULT: begin
                    s_d.rsp.err = 1'b1; // [R7]
                end
                REG_RSV: begin
                    // Reserved registers accept and discard the write.
                    s_d.rsp.err = 1'b0; // [R4]
                end
                default: begin
                    s_d.rsp.err = 1'b1;
                end
            endcase
        end else if (req.rd) begin
            s_d.rsp.ack = 1'b1;
            case (target)
                REG_CTRL:  s_d.rsp.rdata = s_q.ctrlSel; // [R15]
                REG_AOUT1: s_d.rsp.rdata = s_q.aout1;   // [R15]
                REG_AOUT2: s_d.rsp.rdata = s_q.aout2;   // [R15]
                REG_DOUT:  s_d.rsp.rdata = s_q.dout;    // [R15]
                REG_STATE: s_d.rsp.rdata = liveState;   // [R7]
                REG_FAULT: s_d.rsp.rdata = faultLive;   // [R7]
                REG_RSV:   s_d.rsp.rdata = 16'h0000;    // [R4]
                default: begin
                    s_d.rsp.err = 1'b1;
                end
            endcase
        end
        // Steering follows the stored control word, one cycle after a write.
        s_d.sel.pidFromNetwork        = s_d.ctrlSel[CSEL_PID_BIT];    // [R1]
        s_d.sel.torqueFromNetwork     = s_d.ctrlSel[CSEL_TORQUE_BIT]; // [R1]
        s_d.sel.torqueCompFromNetwork = s_d.ctrlSel[CSEL_TCOMP_BIT];  // [R2]
        s_d.sel.broadcastEnable       = s_d.ctrlSel[CSEL_BCAST_LSB +: CSEL_BCAST_W]; // [R3]
    end

    // State register with asynchronous reset to constants.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ctrlSel <= RST_CTRL_SEL;
            s_q.aout1   <= RST_AOUT;
            s_q.aout2   <= RST_AOUT;
            s_q.dout    <= RST_DOUT;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs are straight register copies.
    assign rsp          = s_q.rsp;
    assign sel          = s_q.sel;
    assign analogOutOne = s_q.aout1; // [R5]
    assign analogOutTwo = s_q.aout2; // [R5]
    assign digitalOut   = s_q.dout;  // [R6]

endmodule // dcr_register_map

// ---- hdl/dcr_pkg.sv ----
// Constants and carrier types for the drive network register map.
// Assumes a single 20 MHz clock and word-wide register accesses.
package dcr_pkg;

    // Register indices on the network register port.
    localparam logic [15:0] ADDR_CTRL_SEL   = 16'h000f;
    localparam logic [15:0] ADDR_AOUT_ONE   = 16'h001b;
    localparam logic [15:0] ADDR_AOUT_TWO   = 16'h001c;
    localparam logic [15:0] ADDR_DOUT       = 16'h001d;
    localparam logic [15:0] ADDR_STATE      = 16'h0020;
    localparam logic [15:0] ADDR_FAULT      = 16'h0021;
    localparam logic [15:0] ADDR_RSV_A_LO   = 16'h0010;
    localparam logic [15:0] ADDR_RSV_A_HI   = 16'h001a;
    localparam logic [15:0] ADDR_RSV_B_LO   = 16'h001e;
    localparam logic [15:0] ADDR_RSV_B_HI   = 16'h001f;

    // Reset values of the writable words.
    localparam logic [15:0] RST_CTRL_SEL    = 16'h0000;
    localparam logic [15:0] RST_AOUT        = 16'h0000;
    localparam logic [15:0] RST_DOUT        = 16'h0000;

    // Control-selection field positions.
    localparam int CSEL_PID_BIT    = 1;
    localparam int CSEL_TORQUE_BIT = 2;
    localparam int CSEL_TCOMP_BIT  = 3;
    localparam int CSEL_BCAST_LSB  = 12;
    localparam int CSEL_BCAST_W    = 4;
    // Writable bits of the control-selection word: 1,2,3 and C..F.
    localparam logic [15:0] CSEL_WMASK = 16'hf00e;

    // Drive state word field positions.
    localparam int DS_RUN_BIT   = 0;
    localparam int DS_REV_BIT   = 1;
    localparam int DS_RDY_BIT   = 2;
    localparam int DS_FLT_BIT   = 3;
    localparam int DS_DSE_BIT   = 4;
    localparam int DS_CONT_BIT  = 5;
    localparam int DS_PC1_BIT   = 6;
    localparam int DS_PC2_BIT   = 7;
    localparam int DS_NREF_BIT  = 14;
    localparam int DS_NCTL_BIT  = 15;

    // Fault word bit positions.
    localparam int FW_OC_BIT    = 0;
    localparam int FW_OV_BIT    = 1;
    localparam int FW_OL2_BIT   = 2;
    localparam int FW_HEAT_BIT  = 3;
    localparam int FW_BRK_BIT   = 4;
    localparam int FW_FBL_BIT   = 6;
    localparam int FW_EXT_BIT   = 7;
    localparam int FW_HW_BIT    = 8;
    localparam int FW_MOT_BIT   = 9;
    localparam int FW_ENC_BIT   = 10;
    localparam int FW_MUV_BIT   = 11;
    localparam int FW_UV_BIT    = 12;
    localparam int FW_PH_BIT    = 13;
    localparam int FW_COM_BIT   = 14;
    localparam int FW_KEY_BIT   = 15;

    // Full scale of an analog output word, corresponding to 10 V.
    localparam logic [15:0] AOUT_FULL_SCALE = 16'h4000;

    // Register port request from the network side.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dcr_req_t;

    // Register port answer.
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [15:0] rdata;
    } dcr_rsp_t;

    // Status inputs from drive logic.
    typedef struct packed {
        logic running;
        logic reverse;
        logic ready;
        logic fault;
        logic dataSetError;
        logic contactOut;
        logic photoOut1;
        logic photoOut2;
        logic networkReferenceSelect;
        logic networkControlSelect;
    } dcr_status_t;

    // Individual fault sources from drive logic.
    typedef struct packed {
        logic       overcurrentFault;
        logic       groundFault;
        logic       overvoltageFault;
        logic       driveOverload;
        logic       heatsinkOverheat;
        logic       overheatWarning;
        logic       brakingTransistorFault;
        logic       brakingResistorOverheat;
        logic       feedbackLossLow;
        logic       feedbackLossHigh;
        logic [8:0] externalFault;
        logic       hardwareFault;
        logic       optionCardFault;
        logic       motorOverload;
        logic       overtorqueOne;
        logic       overtorqueTwo;
        logic       undertorqueOne;
        logic       undertorqueTwo;
        logic       encoderDisconnect;
        logic       encoderHwFault;
        logic       overspeed;
        logic       speedDeviation;
        logic       mainUndervoltage;
        logic       dcBusUndervoltage;
        logic       controlSupplyUndervoltage;
        logic       softChargeFault;
        logic       outputPhaseLoss;
        logic       inputPhaseLoss;
        logic       serialCommError;
        logic       optionCommError;
        logic       keypadConnectionFault;
    } dcr_faults_t;

    // Selections steering the drive's reference paths.
    typedef struct packed {
        logic       pidFromNetwork;
        logic       torqueFromNetwork;
        logic       torqueCompFromNetwork;
        logic [3:0] broadcastEnable;
    } dcr_sel_t;

endpackage

// ---- hdl/dcr_fault_merge.sv ----
// Folds the individual fault sources into the sixteen-bit fault word.
// Assumes sources are synchronous levels; the result is combinational.
`timescale 1ns/1ns
module dcr_fault_merge (
    input  dcr_pkg::dcr_faults_t faults,
    output logic [15:0]          faultWord
);
    import dcr_pkg::*;

    // Each bit but the reserved bit 5 is the OR of its group, so it stays set while any source is active; bit 5 reads zero.
    always_comb begin
        faultWord = 16'h0000;
        faultWord[FW_OC_BIT]   = faults.overcurrentFault | faults.groundFault;          // [R9]
        faultWord[FW_OV_BIT]   = faults.overvoltageFault;                               // [R9]
        faultWord[FW_OL2_BIT]  = faults.driveOverload;                                  // [R9]
        faultWord[FW_HEAT_BIT] = faults.heatsinkOverheat | faults.overheatWarning;      // [R9]
        faultWord[FW_BRK_BIT]  = faults.brakingTransistorFault | faults.brakingResistorOverheat; // [R10]
        faultWord[FW_FBL_BIT]  = faults.feedbackLossLow | faults.feedbackLossHigh;      // [R10]
        faultWord[FW_EXT_BIT]  = |faults.externalFault;                                 // [R11]
        faultWord[FW_HW_BIT]   = faults.hardwareFault | faults.optionCardFault;         // [R11]
        faultWord[FW_MOT_BIT]  = faults.motorOverload | faults.overtorqueOne | faults.overtorqueTwo
                               | faults.undertorqueOne | faults.undertorqueTwo;         // [R12]
        faultWord[FW_ENC_BIT]  = faults.encoderDisconnect | faults.encoderHwFault
                               | faults.overspeed | faults.speedDeviation;              // [R12]
        faultWord[FW_MUV_BIT]  = faults.mainUndervoltage;                               // [R13]
        faultWord[FW_UV_BIT]   = faults.dcBusUndervoltage | faults.controlSupplyUndervoltage
                               | faults.softChargeFault;                                // [R13]
        faultWord[FW_PH_BIT]   = faults.outputPhaseLoss | faults.inputPhaseLoss;        // [R14]
        faultWord[FW_COM_BIT]  = faults.serialCommError | faults.optionCommError;       // [R14]
        faultWord[FW_KEY_BIT]  = faults.keypadConnectionFault;                          // [R14] [R17]
    end

endmodule // dcr_fault_merge

// ---- sim/dcr_register_map_sva.sv ----
// Checker for the drive network register map, bound to its top module.
// Assumes one clock domain and the one-cycle request and answer of the register port.
`timescale 1ns/1ns
module dcr_register_map_sva
    import dcr_pkg::*;
#(
    parameter int AOUT_WIDTH = 16,
    parameter int DOUT_WIDTH = 16
) (
    input logic                  clk,
    input logic                  rst_n,
    input dcr_pkg::dcr_req_t     req,
    input dcr_pkg::dcr_rsp_t     rsp,
    input dcr_pkg::dcr_status_t  status,
    input dcr_pkg::dcr_faults_t  faults,
    input dcr_pkg::dcr_sel_t     sel,
    input logic [AOUT_WIDTH-1:0] analogOutOne,
    input logic [AOUT_WIDTH-1:0] analogOutTwo,
    input logic [DOUT_WIDTH-1:0] digitalOut
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] lastWdata_q;
    dcr_status_t lastStatus_q;
    dcr_faults_t lastFaults_q;
    logic        wrCtrl;
    // Keeps what was offered at the request edge, since the answer lands one edge later.
    always_ff @(posedge clk) begin
        lastWdata_q  <= req.wdata;
        lastStatus_q <= status;
        lastFaults_q <= faults;
    end
    assign wrCtrl = req.wr && req.addr == ADDR_CTRL_SEL;
    a_ack_follows_req: assert property (req.rd || req.wr |=> rsp.ack)
        else $error("no answer one cycle after a request");
    a_idle_no_ack: assert property (!(req.rd || req.wr) |=> !rsp.ack && !rsp.err)
        else $error("answer without a request");
    a_monitor_wr_refused: assert property (
        req.wr && (req.addr == ADDR_STATE || req.addr == ADDR_FAULT) |=> rsp.ack && rsp.err)
        else $error("write to a monitor word was not refused");
    a_ctrl_pid_torque: assert property (
        wrCtrl |=> sel.pidFromNetwork == lastWdata_q[1] && sel.torqueFromNetwork == lastWdata_q[2])
        else $error("setpoint or torque selection wrong after write");
    a_ctrl_tcomp: assert property (wrCtrl |=> sel.torqueCompFromNetwork == lastWdata_q[3])
        else $error("compensation selection wrong after write");
    a_ctrl_bcast: assert property (wrCtrl |=> sel.broadcastEnable == lastWdata_q[15:12])
        else $error("broadcast enables wrong after write");
    a_sel_holds: assert property (!wrCtrl |=> $stable(sel))
        else $error("selection changed without a control write");
    a_aout_one_write: assert property (
        req.wr && req.addr == ADDR_AOUT_ONE |=> analogOutOne == lastWdata_q[AOUT_WIDTH-1:0])
        else $error("first analog output does not follow its word");
    a_dout_write: assert property (
        req.wr && req.addr == ADDR_DOUT |=> digitalOut == lastWdata_q[DOUT_WIDTH-1:0])
        else $error("digital outputs do not follow their word");
    a_state_read: assert property (
        req.rd && !req.wr && req.addr == ADDR_STATE
        |=> rsp.rdata[15:8] == {lastStatus_q.networkControlSelect, lastStatus_q.networkReferenceSelect, 6'h00})
        else $error("status word selection bits wrong");
    a_fault_ext_read: assert property (
        req.rd && !req.wr && req.addr == ADDR_FAULT
        |=> rsp.rdata[7] == (|lastFaults_q.externalFault) && !rsp.rdata[5])
        else $error("external fault bit or reserved bit wrong");
    // Main traffic kinds that the bench is expected to reach.
    c_ctrl_write: cover property (wrCtrl);
    c_fault_read: cover property (req.rd && req.addr == ADDR_FAULT);
    c_monitor_write: cover property (req.wr && req.addr == ADDR_STATE);
endmodule // dcr_register_map_sva

bind dcr_register_map dcr_register_map_sva #(.AOUT_WIDTH(AOUT_WIDTH), .DOUT_WIDTH(DOUT_WIDTH)) chk_u (
    .clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .status(status), .faults(faults), .sel(sel),
    .analogOutOne(analogOutOne), .analogOutTwo(analogOutTwo), .digitalOut(digitalOut));

// ---- sim/dcr_net_master.sv ----
// Model of the network master that reads and writes the register words.
// Assumes requests are changed at the falling edge and answered one edge after being taken.
`timescale 1ns/1ns
module dcr_net_master (
    input  logic              clk,
    output dcr_pkg::dcr_req_t req,
    input  dcr_pkg::dcr_rsp_t rsp
);
    import dcr_pkg::*;
    initial req = '0;
    // One word access; the data line is inverted after release so a stale value never looks valid.
    task automatic access(input logic isWr, input logic [15:0] addr, input logic [15:0] wd,
                          output logic [15:0] rdv, output logic ackv, output logic errv);
        @(negedge clk);
        req.rd    = !isWr;
        req.wr    = isWr;
        req.addr  = addr;
        req.wdata = wd;
        @(negedge clk);
        rdv       = rsp.rdata;
        ackv      = rsp.ack;
        errv      = rsp.err;
        req.rd    = 1'b0;
        req.wr    = 1'b0;
        req.wdata = ~wd;
    endtask
endmodule // dcr_net_master

// ---- sim/tb_drive_comm_register_map.sv ----
// Self-checking bench for the drive network register map with a reference model.
// Assumes the master model in its own file and the checker bound to the design.
`timescale 1ns/1ns
module tb_drive_comm_register_map;
    import dcr_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    dcr_req_t    req;
    dcr_rsp_t    rsp;
    dcr_status_t status = '0;
    dcr_faults_t faults = '0;
    dcr_sel_t    sel;
    logic [15:0] analogOutOne, analogOutTwo, digitalOut, v;
    logic [63:0] r;
    logic [15:0] wa[4] = '{ADDR_CTRL_SEL, ADDR_AOUT_ONE, ADDR_AOUT_TWO, ADDR_DOUT};
    int          mdl[4] = '{0, 0, 0, 0};
    int          n_fail = 0;
    int          checks_done = 0;
    int          k;
    always #25 clk = ~clk;
    dcr_register_map dut_u (.clk(clk), .rst_n(rst_n), .req(req), .rsp(rsp), .status(status), .faults(faults),
        .sel(sel), .analogOutOne(analogOutOne), .analogOutTwo(analogOutTwo), .digitalOut(digitalOut));
    dcr_net_master mst_u (.clk(clk), .req(req), .rsp(rsp));
    // Expected monitor words, built field by field.
    function automatic logic [15:0] expState(dcr_status_t s);
        return {s.networkControlSelect, s.networkReferenceSelect, 6'h00, s.photoOut2, s.photoOut1,
                s.contactOut, s.dataSetError, s.fault, s.ready, s.reverse, s.running};
    endfunction
    function automatic logic [15:0] expFault(dcr_faults_t f);
        return {f.keypadConnectionFault, f.serialCommError | f.optionCommError,
                f.outputPhaseLoss | f.inputPhaseLoss,
                f.dcBusUndervoltage | f.controlSupplyUndervoltage | f.softChargeFault, f.mainUndervoltage,
                f.encoderDisconnect | f.encoderHwFault | f.overspeed | f.speedDeviation,
                f.motorOverload | f.overtorqueOne | f.overtorqueTwo | f.undertorqueOne | f.undertorqueTwo,
                f.hardwareFault | f.optionCardFault, |f.externalFault, f.feedbackLossLow | f.feedbackLossHigh,
                1'b0, f.brakingTransistorFault | f.brakingResistorOverheat, f.heatsinkOverheat | f.overheatWarning,
                f.driveOverload, f.overvoltageFault, f.overcurrentFault | f.groundFault};
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One access with its answer checked; read data is only meaningful on reads.
    task automatic xfer(input logic isWr, input logic [15:0] addr, input logic [15:0] wd,
                        input logic [15:0] expRd, input logic expErr);
        logic [15:0] rdv;
        logic        ackv;
        logic        errv;
        mst_u.access(isWr, addr, wd, rdv, ackv, errv);
        chk("ack", 16'(ackv), 16'h0001);
        chk("err", 16'(errv), 16'(expErr));
        if (!isWr) chk("rdata", rdv, expRd);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Cuts a hang short well past the few hundred cycles the sequence needs.
    initial begin
        #(3000 * 50);
        n_fail++;
        report_and_stop();
    end
    // Main sequence: reset, command words, monitor words, single fault sources, reserved places.
    initial begin
        void'($urandom(70072));
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) xfer(1'b0, wa[i], 16'h0000, 16'h0000, 1'b0);
        xfer(1'b1, ADDR_AOUT_ONE, AOUT_FULL_SCALE, 16'h0000, 1'b0);
        mdl[1] = AOUT_FULL_SCALE;
        repeat (40) begin
            k = $urandom_range(3);
            v = 16'($urandom);
            if (k == 0) v = v & CSEL_WMASK;
            mdl[k] = v;
            xfer(1'b1, wa[k], v, 16'h0000, 1'b0);
            v = 16'(mdl[0]);
            chk("sel", 16'(sel), {9'h000, v[1], v[2], v[3], v[15:12]});
            chk("aoutOne", analogOutOne, 16'(mdl[1]));
            chk("aoutTwo", analogOutTwo, 16'(mdl[2]));
            chk("dout", digitalOut, 16'(mdl[3]));
            xfer(1'b0, wa[k], 16'h0000, 16'(mdl[k]), 1'b0);
        end
        repeat (20) begin
            r = {$urandom, $urandom};
            status = r[$bits(dcr_status_t)+15:16];
            faults = r[$bits(dcr_faults_t)-1:0];
            xfer(1'b1, (r[0] ? ADDR_FAULT : ADDR_STATE), r[15:0], 16'h0000, 1'b1);
            xfer(1'b0, ADDR_STATE, 16'h0000, expState(status), 1'b0);
            xfer(1'b0, ADDR_FAULT, 16'h0000, expFault(faults), 1'b0);
        end
        for (int i = 0; i < $bits(dcr_faults_t); i++) begin
            r = 64'h1 << i;
            faults = r[$bits(dcr_faults_t)-1:0];
            xfer(1'b0, ADDR_FAULT, 16'h0000, expFault(faults), 1'b0);
        end
        for (int a = 16'h10; a <= 16'h1f; a++)
            if (a < 16'h1b || a > 16'h1d) xfer(1'b0, 16'(a), 16'h0000, 16'h0000, 1'b0);
        // Reserved bits and registers must swallow whatever a careless master sends.
        xfer(1'b1, ADDR_CTRL_SEL, 16'hffff, 16'h0000, 1'b0);
        xfer(1'b0, ADDR_CTRL_SEL, 16'h0000, CSEL_WMASK, 1'b0);
        chk("selAll", 16'(sel), 16'h007f);
        xfer(1'b1, ADDR_RSV_A_LO, 16'hffff, 16'h0000, 1'b0);
        xfer(1'b0, ADDR_RSV_A_LO, 16'h0000, 16'h0000, 1'b0);
        xfer(1'b0, 16'h0022, 16'h0000, 16'h0000, 1'b1);
        chk("doutKept", digitalOut, 16'(mdl[3]));
        report_and_stop();
    end
endmodule // tb_drive_comm_register_map
